// ===== hw/ast_uart_tx.sv
// ast_uart_tx: asynchronous serial transmitter with ahb-lite registers
// assumes: single 40 mhz clock hclk; external shift clock arrives on a pin
// Operation
// R1: asynchronous mode runs only while the mode select bit is zero.
// R2: transmit and receive share one shift clock and frame format.
// R3: clock select: 0 takes divider output/16, 1 external pin/16.
// R4: with divider clock, the external clock pin stays undriven.
// R5: bit rate is osc / (prescale x (setting + 1) x 16).
// R6: prescale ratio is 4 when source bit is 0, else 16.
// R7: divider setting is 8 bits, 0 through 255, software written.
// R8: format b0: 0 gives 8 data bits, 1 gives 7.
// R9: format b1 set appends a parity bit after the data.
// R10: format b2: 0 even ones count, 1 odd ones count.
// R11: format b3: 0 one stop bit, 1 two stop bits.
// R12: every frame opens with one low start bit.
// R13: data 0 is a low line, data 1 a high line.
// R14: stop bits follow data, or parity when parity enabled.
// R15: writing the transmit buffer clears buffer empty.
// R16: moving buffer to shift register sets buffer empty.
// R17: start bit leaves at a falling shift clock edge after load.
// R18: next falling edge sends lsb, shifts, clears shift complete.
// R19: one shift per falling edge, length bits, lsb first.
// R20: divider clock stops at completion; back-to-back keeps it running.
// R21: source bit 0: request set at buffer-to-shift move.
// R22: source bit 1: request set when frame shifting finishes.
// R23: software writes the next byte only while buffer empty reads 1.
// R24: 7-bit parity covers only seven sent bits, ignoring bit 7.
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ast_cfg.svh"

module ast_uart_tx
    import ast_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_clk_in,
    output logic             ext_clk_oe_n,
    output logic             txd,
    output logic             tx_irq
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [4:0]  ctrl_q;
    logic [3:0]  fmt_q;
    logic [7:0]  div_q;
    logic [7:0]  txbuf_q;
    logic        tbe_q;
    logic        tsc_q;
    logic        irq_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [7:0]  shreg_q;
    logic        par_q;
    logic [2:0]  bitcnt_q;
    logic        stop2_q;
    ast_state_e  state_q;
    logic [3:0]  pre_q;
    logic [7:0]  dcnt_q;
    logic [3:0]  sub_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;

    logic        en_async;
    logic        tick16;
    logic        bit_tick;
    logic        buf_wr;
    logic        load;
    logic        done;
    logic        pre_tick;
    logic [3:0]  pre_max;
    logic        div_halt;

    assign en_async = ~ctrl_q[`AST_CTRL_ASYNC_N]
                    & ctrl_q[`AST_CTRL_TXEN];  // R1

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    // zero wait states; write lands at the end of the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel & htrans[1] & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // read data is registered so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                `AST_OFS_CTRL:   hrdata <= {27'h0, ctrl_q};
                `AST_OFS_FRAME:  hrdata <= {28'h0, fmt_q};
                `AST_OFS_DIV:    hrdata <= {24'h0, div_q};
                `AST_OFS_TXBUF:  hrdata <= {24'h0, txbuf_q};
                `AST_OFS_STATUS: hrdata <= {29'h0, irq_q, tsc_q, tbe_q};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign buf_wr = wr_pend_q && (wr_addr_q == `AST_OFS_TXBUF);

    // software-written configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= `AST_CTRL_RST;
            fmt_q   <= `AST_FMT_RST;
            div_q   <= `AST_DIV_RST;
            txbuf_q <= 8'h00;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                `AST_OFS_CTRL:  ctrl_q  <= hwdata[4:0];
                `AST_OFS_FRAME: fmt_q   <= hwdata[3:0];
                `AST_OFS_DIV:   div_q   <= hwdata[7:0];  // R7
                `AST_OFS_TXBUF: txbuf_q <= hwdata[7:0];
                default:        ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // shift clock: prescaler, rate divider, external pin, /16
    // ------------------------------------------------------------------
    assign pre_max  = ctrl_q[`AST_CTRL_PRE16] ? 4'(`AST_PRE_HI - 1)
                                              : 4'(`AST_PRE_LO - 1);  // R6
    assign pre_tick = (pre_q == pre_max);

    // parked while async mode is off, or with no frame running and nothing buffered to send
    assign div_halt = !en_async || (state_q == AST_IDLE && tbe_q);

    // divider clock halts when idle so frames start on a fresh period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q  <= 4'h0;
            dcnt_q <= 8'h00;
        end else if (div_halt) begin
            pre_q  <= 4'h0;  // R20
            dcnt_q <= 8'h00;
        end else if (pre_tick) begin
            pre_q  <= 4'h0;
            dcnt_q <= (dcnt_q == div_q) ? 8'h00 : dcnt_q + 8'h01;  // R5
        end else begin
            pre_q  <= pre_q + 4'h1;
        end
    end

    // pin clock passes two flops; third stage only feeds edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            ext_s3_q <= 1'b1;
        end else begin
            ext_s1_q <= ext_clk_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // one pulse per divider period or external falling edge
    always_comb begin
        if (ctrl_q[`AST_CTRL_EXTCLK])
            tick16 = ext_s3_q & ~ext_s2_q;  // R3
        else
            tick16 = pre_tick && (dcnt_q == div_q);  // R3
    end

    // common /16 stage; bit_tick stands for the falling shift clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_q <= 4'h0;
        end else if (div_halt) begin
            sub_q <= 4'h0;
        end else if (tick16) begin
            sub_q <= sub_q + 4'h1;  // R2
        end
    end
    assign bit_tick = tick16 && (sub_q == 4'(`AST_OVERSAMPLE - 1));

    // external clock pin: output enable held off, left as a port line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_clk_oe_n <= 1'b1;
        end else begin
            ext_clk_oe_n <= 1'b1;  // R4
        end
    end

    // ------------------------------------------------------------------
    // transmit sequencer
    // ------------------------------------------------------------------
    assign load = en_async && !tbe_q && bit_tick
                && (state_q == AST_IDLE || done);  // R20
    assign done = bit_tick && state_q == AST_STOP && !stop2_q;

    // buffer empty: write clears, move sets; write wins over move
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbe_q <= 1'b1;
        end else if (buf_wr) begin
            tbe_q <= 1'b0;  // R15
        end else if (load) begin
            tbe_q <= 1'b1;  // R16
        end
    end

    // shift complete flag: set at frame end unless a buffered byte loads at that edge, cleared with first data bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tsc_q <= 1'b1;
        end else if (done && !load) begin
            tsc_q <= 1'b1;
        end else if (bit_tick && state_q == AST_START) begin
            tsc_q <= 1'b0;  // R18
        end
    end

    // frame walk: start, data lsb first, parity, stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= AST_IDLE;
            shreg_q  <= 8'h00;
            par_q    <= 1'b0;
            bitcnt_q <= 3'h0;
            stop2_q  <= 1'b0;
            txd      <= 1'b1;
        end else if (!en_async) begin
            state_q  <= AST_IDLE;
            txd      <= 1'b1;
        end else if (load) begin
            state_q  <= AST_START;
            shreg_q  <= txbuf_q;
            // parity over sent bits only; even sense starts at zero
            par_q    <= fmt_q[`AST_FMT_PARODD]
                      ^ (^txbuf_q[6:0])
                      ^ (txbuf_q[7] & ~fmt_q[`AST_FMT_LEN7]);  // R10 R24
            bitcnt_q <= fmt_q[`AST_FMT_LEN7] ? 3'h6 : 3'h7;  // R8
            txd      <= 1'b0;  // R12 R17
        end else if (bit_tick) begin
            unique case (state_q)
                AST_IDLE: begin
                    txd <= 1'b1;
                end
                AST_START, AST_DATA: begin
                    if (state_q == AST_DATA && bitcnt_q == 3'h0) begin
                        state_q <= fmt_q[`AST_FMT_PAREN] ? AST_PARITY
                                                         : AST_STOP;  // R9
                        txd     <= fmt_q[`AST_FMT_PAREN] ? par_q
                                                         : 1'b1;  // R14
                        stop2_q <= fmt_q[`AST_FMT_STOP2];  // R11
                    end else begin
                        if (state_q == AST_DATA)
                            bitcnt_q <= bitcnt_q - 3'h1;  // R19
                        state_q <= AST_DATA;
                        txd     <= shreg_q[0];  // R13 R18
                        shreg_q <= {1'b0, shreg_q[7:1]};
                    end
                end
                AST_PARITY: begin
                    state_q <= AST_STOP;
                    txd     <= 1'b1;  // R14
                end
                AST_STOP: begin
                    if (stop2_q) begin
                        stop2_q <= 1'b0;  // R11
                    end else begin
                        state_q <= AST_IDLE;
                    end
                    txd <= 1'b1;
                end
                default: begin
                    state_q <= AST_IDLE;
                    txd     <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // transmit interrupt request; cleared by writing the status word with its irq bit set
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else if (load && !ctrl_q[`AST_CTRL_IRQSRC]) begin
            irq_q <= 1'b1;  // R21
        end else if (done && ctrl_q[`AST_CTRL_IRQSRC]) begin
            irq_q <= 1'b1;  // R22
        end else if (wr_pend_q && wr_addr_q == `AST_OFS_STATUS
                     && hwdata[`AST_ST_IRQ]) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            tx_irq <= 1'b0;
        else
            tx_irq <= irq_q;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_WR_CLEARS_TBE: assert property (@(posedge hclk) // R15
        disable iff (!hresetn) buf_wr |=> !tbe_q)
        else $error("buffer write left empty set");
    AST_LOAD_SETS_TBE: assert property (@(posedge hclk) // R16
        disable iff (!hresetn) load && !buf_wr |=> tbe_q)
        else $error("move left empty clear");
    AST_START_LOW: assert property (@(posedge hclk) // R17
        disable iff (!hresetn) load |=> !txd && state_q == AST_START)
        else $error("start bit not low");
    AST_FIRST_BIT: assert property (@(posedge hclk) // R18
        disable iff (!hresetn)
        en_async && bit_tick && state_q == AST_START && !load
        |=> txd == $past(shreg_q[0]) && !tsc_q)
        else $error("lsb not sent first");
    AST_IDLE_HIGH: assert property (@(posedge hclk) // R13
        disable iff (!hresetn) state_q == AST_IDLE && !load |=> txd)
        else $error("line not high when idle");
    AST_IRQ_MOVE: assert property (@(posedge hclk) // R21
        disable iff (!hresetn)
        load && !ctrl_q[`AST_CTRL_IRQSRC] |=> ##1 tx_irq)
        else $error("no request on move");
    AST_IRQ_DONE: assert property (@(posedge hclk) // R22
        disable iff (!hresetn) done && ctrl_q[`AST_CTRL_IRQSRC] |=> irq_q)
        else $error("no request at completion");
    AST_PIN_FREE: assert property (@(posedge hclk) // R4
        disable iff (!hresetn) !ctrl_q[`AST_CTRL_EXTCLK] |-> ext_clk_oe_n)
        else $error("clock pin driven");
    AST_OFF_IDLE: assert property (@(posedge hclk) // R1
        disable iff (!hresetn)
        ctrl_q[`AST_CTRL_ASYNC_N] |=> state_q == AST_IDLE)
        else $error("sequencer ran outside async mode");
    AST_DATA_LSB: assert property (@(posedge hclk) // R19
        disable iff (!hresetn)
        en_async && bit_tick && state_q == AST_DATA && bitcnt_q != 3'h0
        |=> txd == $past(shreg_q[0]))
        else $error("data bit order");
    AST_PAR_STOP: assert property (@(posedge hclk) // R14
        disable iff (!hresetn)
        en_async && bit_tick && state_q == AST_PARITY
        |=> txd && state_q == AST_STOP)
        else $error("no stop after parity");

endmodule

// ===== include/ast_cfg.svh
// ast_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the transmitter and the bench; definitions only
`ifndef AST_CFG_SVH
`define AST_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define AST_OFS_CTRL     8'h00
`define AST_OFS_FRAME    8'h04
`define AST_OFS_DIV      8'h08
`define AST_OFS_TXBUF    8'h0c
`define AST_OFS_STATUS   8'h10

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define AST_CTRL_ASYNC_N 0
`define AST_CTRL_EXTCLK  1
`define AST_CTRL_PRE16   2
`define AST_CTRL_IRQSRC  3
`define AST_CTRL_TXEN    4
`define AST_CTRL_RST     5'h00

// ----------------------------------------------------------------------
// frame format fields
// ----------------------------------------------------------------------
`define AST_FMT_LEN7     0
`define AST_FMT_PAREN    1
`define AST_FMT_PARODD   2
`define AST_FMT_STOP2    3
`define AST_FMT_RST      4'h0
`define AST_DIV_RST      8'h00

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define AST_ST_TBE       0
`define AST_ST_TSC       1
`define AST_ST_IRQ       2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define AST_OVERSAMPLE   16
`define AST_PRE_LO       4
`define AST_PRE_HI       16

`endif

// ===== include/ast_pkg.sv
// ast_pkg: types shared by the serial transmitter
// assumes: compiled before the design module
package ast_pkg;
    // transmit sequencer states
    typedef enum logic [2:0] {
        AST_IDLE   = 3'b000,
        AST_START  = 3'b001,
        AST_DATA   = 3'b010,
        AST_PARITY = 3'b011,
        AST_STOP   = 3'b100
    } ast_state_e;
endpackage

// ===== verification/ast_remote_rx.sv
// ast_remote_rx: far-end receiver that decodes frames seen on txd
// assumes: shares hclk with the bench; bit_cycles set to the live rate
`timescale 1ns/10ps

module ast_remote_rx (
    input  wire logic        hclk,
    input  wire logic        txd,
    input  wire logic        len7,
    input  wire logic        par_en,
    input  wire logic        stop2,
    input  wire logic [15:0] bit_cycles,
    input  wire logic        ext_run,
    input  wire logic [7:0]  ext_half,
    output logic             ext_clk,
    output logic [7:0]       rx_data,
    output logic             rx_par,
    output logic [1:0]       rx_stops,
    output logic [15:0]      rx_count
);
    logic [7:0] ext_cnt;
    logic       prev;
    int         i;

    // ------------------------------------------------------------------
    // clock pin source
    // ------------------------------------------------------------------
    // stands low while not asked to run, never free-running
    always @(posedge hclk) begin
        if (ext_run !== 1'b1) begin
            ext_cnt <= 8'h00;
            ext_clk <= 1'b0;
        end else if (ext_cnt == ext_half - 8'h01) begin
            ext_cnt <= 8'h00;
            ext_clk <= ~ext_clk;
        end else begin
            ext_cnt <= ext_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // frame decoder
    // ------------------------------------------------------------------
    // samples mid-bit so a phase slip of a few cycles is tolerated
    initial begin
        rx_data  = 8'h00;
        rx_par   = 1'b0;
        rx_stops = 2'h0;
        rx_count = 16'h0000;
        prev     = 1'b1;
        forever begin
            @(posedge hclk);
            if (prev === 1'b1 && txd === 1'b0) begin
                repeat (bit_cycles / 2 - 1) @(posedge hclk);
                if (txd === 1'b0) begin
                    rx_data = 8'h00;
                    for (i = 0; i < (len7 ? 7 : 8); i++) begin
                        repeat (bit_cycles) @(posedge hclk);
                        rx_data[i] = txd;
                    end
                    if (par_en) begin
                        repeat (bit_cycles) @(posedge hclk);
                        rx_par = txd;
                    end
                    rx_stops = 2'h0;
                    for (i = 0; i < (stop2 ? 2 : 1); i++) begin
                        repeat (bit_cycles) @(posedge hclk);
                        if (txd === 1'b1) rx_stops++;
                    end
                    rx_count++;
                end
            end
            prev = txd;
        end
    end
endmodule

// ===== verification/ast_uart_tx_bench.sv
// ast_uart_tx_bench: directed scenarios for the serial transmitter
// assumes: ast_pkg, ast_cfg.svh and ast_remote_rx compiled beforehand
`timescale 1ns/10ps
`include "ast_cfg.svh"

module ast_uart_tx_bench;
    logic        hclk, hresetn, hsel, hwrite, ext_clk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, ext_clk_oe_n, txd, tx_irq;
    logic        len7, par_en, stop2, ext_run, rx_par;
    logic [15:0] bit_cycles, rx_count;
    logic [7:0]  ext_half, rx_data;
    logic [1:0]  rx_stops;
    int          n_errors, n_checks;

    // ------------------------------------------------------------------
    // clock, instances, pin watch
    // ------------------------------------------------------------------
    // 40 mhz
    always #12.5 hclk = ~hclk;

    ast_uart_tx u_ast_uart_tx (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_clk_in(ext_clk), .ext_clk_oe_n(ext_clk_oe_n), .txd(txd),
        .tx_irq(tx_irq));

    ast_remote_rx u_ast_remote_rx (.hclk(hclk), .txd(txd), .len7(len7),
        .par_en(par_en), .stop2(stop2), .bit_cycles(bit_cycles),
        .ext_run(ext_run), .ext_half(ext_half), .ext_clk(ext_clk),
        .rx_data(rx_data), .rx_par(rx_par), .rx_stops(rx_stops),
        .rx_count(rx_count));

    // the clock pin must never be driven, whatever the clock source
    always @(posedge hclk) begin
        if (hresetn === 1'b1 && ext_clk_oe_n !== 1'b1) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, ext_clk_oe_n, 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic timeout;
        n_errors++;
        $display("ERROR t=%0t wait expired got=%h exp=%h", $time, 0, 1);
        end_of_test;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single-word transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        i = 0;
        do begin @(posedge hclk); i++; end
        while (hreadyout !== 1'b1 && i < 100);
        if (i >= 100) timeout;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        i = 0;
        do begin @(posedge hclk); i++; end
        while (hreadyout !== 1'b1 && i < 100);
        if (i >= 100) timeout;
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int i;
        i = 0;
        do begin ahb(1'b0, `AST_OFS_STATUS, 32'h0); i++; end
        while ((rd & m) !== e && i < 10000);
        if ((rd & m) !== e) timeout;
    endtask

    task automatic wait_rx(input logic [15:0] n0);
        int i;
        i = 0;
        while (rx_count === n0 && i < 20000) begin @(posedge hclk); i++; end
        if (i >= 20000) timeout;
    endtask

    // partner rate follows the configured divider or the pin clock
    task automatic cfg(input logic [7:0] c, input logic [3:0] f,
                       input logic [7:0] dv);
        wr(`AST_OFS_CTRL, {24'h0, c});
        wr(`AST_OFS_FRAME, {28'h0, f});
        wr(`AST_OFS_DIV, {24'h0, dv});
        len7 <= f[0];
        par_en <= f[1];
        stop2 <= f[3];
        bit_cycles <= c[1] ? 16'd128 :
            (c[2] ? 16'd16 : 16'd4) * ({8'h0, dv} + 16'd1) * 16'd16;
    endtask

    // waits for shift complete so reconfiguring never cuts a frame
    task automatic send(input logic [7:0] d);
        logic [15:0] n0;
        n0 = rx_count;
        wr(`AST_OFS_TXBUF, {24'h0, d});
        wait_rx(n0);
        poll(32'h2, 32'h2);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check(32'({txd, tx_irq, hresp}), 32'h4);
        ahb(1'b0, `AST_OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `AST_OFS_FRAME, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `AST_OFS_STATUS, 32'h0);
        check(rd, 32'h3);
        wr(8'h14, 32'hffffffff);
        ahb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        wr(`AST_OFS_DIV, 32'h000000ff);
        ahb(1'b0, `AST_OFS_DIV, 32'h0);
        check(rd, 32'h000000ff);
        $display("test reset done");
    endtask

    task automatic t_formats;
        logic [3:0] fm;
        logic [7:0] d;
        for (int f = 0; f < 16; f++) begin
            fm = f[3:0];
            d = 8'h96 ^ {fm, fm};
            cfg(8'h10, fm, 8'h00);
            send(d);
            check(32'(fm[0] ? {1'b0, d[6:0]} : d), 32'(rx_data));
            if (fm[1])
                check(32'((fm[0] ? ^d[6:0] : ^d) ^ fm[2]), 32'(rx_par));
            check(fm[3] ? 32'd2 : 32'd1, 32'(rx_stops));
        end
        $display("test formats done");
    endtask

    task automatic t_rate;
        int i, n;
        logic [7:0] dv;
        logic [15:0] n0;
        for (int k = 0; k < 3; k++) begin
            dv = (k == 0) ? 8'h00 : ((k == 1) ? 8'h02 : 8'h09);
            cfg((k == 1) ? 8'h14 : 8'h10, 4'h0, dv);
            n0 = rx_count;
            wr(`AST_OFS_TXBUF, 32'h000000ff);
            i = 0;
            while (txd !== 1'b0 && i < 40000) begin @(posedge hclk); i++; end
            if (i >= 40000) timeout;
            n = 0;
            while (txd === 1'b0 && n < 40000) begin @(posedge hclk); n++; end
            check(32'(n), ((k == 1) ? 32'd16 : 32'd4) * (dv + 1) * 16);
            wait_rx(n0);
            poll(32'h2, 32'h2);
        end
        $display("test rate done");
    endtask

    task automatic t_back2back;
        logic [15:0] n0;
        cfg(8'h10, 4'h8, 8'h00);
        wr(`AST_OFS_STATUS, 32'h4);
        n0 = rx_count;
        wr(`AST_OFS_TXBUF, 32'h0000003c);
        poll(32'h1, 32'h1);
        check(rd & 32'h4, 32'h4);
        check(32'(tx_irq), 32'h1);
        poll(32'h2, 32'h0);
        wr(`AST_OFS_TXBUF, 32'h000000c3);
        ahb(1'b0, `AST_OFS_STATUS, 32'h0);
        check(rd & 32'h1, 32'h0);
        wait_rx(n0);
        check(32'(rx_data), 32'h3c);
        wait_rx(n0 + 16'd1);
        check(32'({rx_data, rx_stops}), 32'h30e);
        poll(32'h2, 32'h2);
        $display("test back to back done");
    endtask

    task automatic t_irq_done;
        logic [15:0] n0;
        cfg(8'h18, 4'h0, 8'h00);
        wr(`AST_OFS_STATUS, 32'h4);
        n0 = rx_count;
        wr(`AST_OFS_TXBUF, 32'h00000055);
        poll(32'h1, 32'h1);
        check(rd & 32'h4, 32'h0);
        wait_rx(n0);
        poll(32'h4, 32'h4);
        check(32'(tx_irq), 32'h1);
        wr(`AST_OFS_STATUS, 32'h4);
        ahb(1'b0, `AST_OFS_STATUS, 32'h0);
        check(32'({tx_irq, rd[2]}), 32'h0);
        $display("test irq on completion done");
    endtask

    task automatic t_ext_clock;
        cfg(8'h12, 4'h0, 8'h00);
        ext_run <= 1'b1;
        send(8'h5a);
        check(32'(rx_data), 32'h5a);
        ext_run <= 1'b0;
        $display("test pin clock done");
    endtask

    task automatic t_mode_off;
        int n;
        logic [15:0] n0;
        cfg(8'h11, 4'h0, 8'h00);
        n0 = rx_count;
        wr(`AST_OFS_TXBUF, 32'h00000000);
        n = 0;
        repeat (300) begin @(posedge hclk); if (txd !== 1'b1) n++; end
        check(32'(n), 32'h0);
        check(32'(rx_count), 32'(n0));
        $display("test mode off done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {len7, par_en, stop2, ext_run} = 4'h0;
        ext_half = 8'h04;
        bit_cycles = 16'd64;
        n_errors = 0;
        n_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_formats;
        t_rate;
        t_back2back;
        t_irq_done;
        t_ext_clock;
        t_mode_off;
        end_of_test;
    end
endmodule
